// *** common/qsb_regs.svh ***
// Widths, depths and field positions of the burst-four static RAM port
`ifndef QSB_REGS_SVH
`define QSB_REGS_SVH
`define QSB_DATA_W 36
`define QSB_LANES 4
`define QSB_LANE_W 9
`define QSB_ADDR_W 18
`define QSB_MEM_AW 4
`define QSB_BURST 4
`define QSB_BEAT_W 2
`define QSB_MEM_WORDS 64
`define QSB_IDX_W 6
`define QSB_FIFO_DEPTH 8
`endif

// *** common/qsb_pkg.sv ***
// Types shared by the burst-four static RAM port
`include "qsb_regs.svh"
package qsb_pkg;
  typedef logic [`QSB_DATA_W-1:0] qsb_data_t;
  typedef logic [`QSB_LANES-1:0] qsb_lane_t;
  typedef logic [`QSB_ADDR_W-1:0] qsb_addr_t;
  typedef logic [`QSB_BEAT_W-1:0] qsb_beat_t;
  typedef logic [`QSB_IDX_W-1:0] qsb_idx_t;

  // Whole state of the port core
  typedef struct packed {
    logic kt_prev;
    logic kc_prev;
    logic ct_prev;
    logic cc_prev;
    logic rd_block;
    logic wr_block;
    logic wr_act;
    qsb_beat_t wr_beat;
    qsb_addr_t wr_addr;
    logic rd_act;
    qsb_beat_t rd_beat;
    qsb_addr_t rd_addr;
    qsb_beat_t out_beat;
    qsb_data_t dout;
    logic oe;
    logic echo_t;
    logic echo_c;
    logic [`QSB_MEM_WORDS-1:0][`QSB_DATA_W-1:0] mem;
  } qsb_core_s;
endpackage : qsb_pkg

// *** rtl/qsb_fifo.sv ***
// Parameterised valid/ready FIFO with registered read data
`timescale 1ns/1ps
module qsb_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic [WIDTH-1:0] dout;
    logic dvalid;
  } qsb_fifo_s;

  qsb_fifo_s st_r;
  qsb_fifo_s st_nxt;
  logic push;
  logic pop_mem;

  // Output register refills whenever it is empty or being taken
  always_comb begin
    st_nxt = st_r;
    push = in_valid && (st_r.cnt != DEPTH[AW:0]);
    pop_mem = (st_r.cnt != '0) && (!st_r.dvalid || out_ready);
    if (out_ready && st_r.dvalid) begin
      st_nxt.dvalid = 1'b0;
    end
    if (push) begin
      st_nxt.mem[st_r.wp] = in_data;
      st_nxt.wp = (st_r.wp == AW'(DEPTH - 1)) ? '0 : st_r.wp + 1'b1;
    end
    if (pop_mem) begin
      st_nxt.dout = st_r.mem[st_r.rp];
      st_nxt.dvalid = 1'b1;
      st_nxt.rp = (st_r.rp == AW'(DEPTH - 1)) ? '0 : st_r.rp + 1'b1;
    end
    st_nxt.cnt = st_r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop_mem};
  end

  // State register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign in_ready = (st_r.cnt != DEPTH[AW:0]);
  assign out_valid = st_r.dvalid;
  assign out_data = st_r.dout;
endmodule : qsb_fifo

// *** rtl/qsb_port.sv ***
// Synchronous port of a burst-four static RAM with separate read and write buses
`timescale 1ns/1ps
`include "qsb_regs.svh"
module qsb_port (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic input_clock_true,
  input wire logic input_clock_comp,
  input wire logic output_clock_true,
  input wire logic output_clock_comp,
  input wire qsb_pkg::qsb_addr_t address,
  input wire logic read_select_n,
  input wire logic write_select_n,
  input wire qsb_pkg::qsb_data_t write_data_in,
  input wire qsb_pkg::qsb_lane_t byte_lane_enable_n,
  output qsb_pkg::qsb_data_t read_data_out,
  output logic read_data_oe,
  output logic echo_clock_true,
  output logic echo_clock_comp
);
  import qsb_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Storage index of one beat inside a burst
  // Four beats share one burst address; the beat number fills the low index bits
  function automatic qsb_idx_t mem_index(input qsb_addr_t a, input qsb_beat_t b);
    mem_index = {a[`QSB_MEM_AW-1:0], b};
  endfunction : mem_index

  // Lane-wise merge, a low enable replaces the lane
  function automatic qsb_data_t lane_merge(input qsb_data_t old_w, input qsb_data_t new_w, input qsb_lane_t en_n);
    lane_merge = old_w;
    for (int i = 0; i < `QSB_LANES; i++) begin
      if (!en_n[i]) begin
        lane_merge[i*`QSB_LANE_W +: `QSB_LANE_W] = new_w[i*`QSB_LANE_W +: `QSB_LANE_W];
      end
    end
  endfunction : lane_merge

  qsb_core_s st_r;
  qsb_core_s st_nxt;
  logic kt_rise;
  logic kc_rise;
  logic ct_rise;
  logic cc_rise;
  logic single_clk;
  logic ref_t_rise;
  logic ref_c_rise;
  logic data_edge;
  logic rd_accept;
  logic wr_accept;
  logic edge_ok;
  logic fifo_in_ready;
  logic fifo_out_valid;
  qsb_data_t fifo_out_data;
  qsb_data_t fetch_word;

  // ----------------------------------------------------------------
  // Edge detection and command decode
  // ----------------------------------------------------------------
  // Clock pins are sampled levels; a rise is high now, low before
  // Previous samples clear to low in reset, so a pin already high reads as a rise
  // at the first edge after release; nothing is active then, so it is harmless
  assign kt_rise = input_clock_true && !st_r.kt_prev;
  assign kc_rise = input_clock_comp && !st_r.kc_prev;
  assign ct_rise = output_clock_true && !st_r.ct_prev;
  assign cc_rise = output_clock_comp && !st_r.cc_prev;
  assign data_edge = kt_rise || kc_rise;
  // Both output clocks high selects the input pair as reference
  assign single_clk = output_clock_true && output_clock_comp;
  assign ref_t_rise = single_clk ? kt_rise : ct_rise;
  assign ref_c_rise = single_clk ? kc_rise : cc_rise;
  // Commands taken only on true clock rise, and not right after the same kind
  // Both selects high decode to a deselect cycle: nothing is latched
  assign rd_accept = kt_rise && !read_select_n && !st_r.rd_block;
  assign wr_accept = kt_rise && !write_select_n && !st_r.wr_block;
  // Output slot: even beats wait for comp edge, odd for true edge
  assign edge_ok = st_r.out_beat[0] ? ref_t_rise : ref_c_rise;
  assign fetch_word = st_r.mem[mem_index(st_r.rd_addr, st_r.rd_beat)];

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Next state of the port core, one copy of the state struct; the read FIFO keeps its own
  always_comb begin
    st_nxt = st_r;
    st_nxt.kt_prev = input_clock_true;
    st_nxt.kc_prev = input_clock_comp;
    st_nxt.ct_prev = output_clock_true;
    st_nxt.cc_prev = output_clock_comp;
    // Echo clocks follow the active reference, running even when tristated
    // Registered beside the data so their rises line up with each word
    st_nxt.echo_t = single_clk ? input_clock_true : output_clock_true;
    st_nxt.echo_c = single_clk ? input_clock_comp : output_clock_comp;
    // Block flags refresh on each true edge only
    if (kt_rise) begin
      st_nxt.rd_block = rd_accept;
      st_nxt.wr_block = wr_accept;
    end
    // Write beats: one word per input clock rise after the command
    if (st_r.wr_act && data_edge) begin
      st_nxt.mem[mem_index(st_r.wr_addr, st_r.wr_beat)] =
        lane_merge(st_r.mem[mem_index(st_r.wr_addr, st_r.wr_beat)], write_data_in, byte_lane_enable_n);
      st_nxt.wr_beat = st_r.wr_beat + 1'b1;
      if (st_r.wr_beat == `QSB_BEAT_W'(`QSB_BURST - 1)) begin
        st_nxt.wr_act = 1'b0;
      end
    end
    // New write command wins over the ending burst
    if (wr_accept) begin
      st_nxt.wr_addr = address;
      st_nxt.wr_act = 1'b1;
      st_nxt.wr_beat = '0;
    end
    // Read fetch pushes four words, stalled by a full FIFO
    // A read taken mid-fetch restarts it; controller spacing keeps that away
    if (st_r.rd_act && fifo_in_ready) begin
      st_nxt.rd_beat = st_r.rd_beat + 1'b1;
      if (st_r.rd_beat == `QSB_BEAT_W'(`QSB_BURST - 1)) begin
        st_nxt.rd_act = 1'b0;
      end
    end
    if (rd_accept) begin
      st_nxt.rd_addr = address;
      st_nxt.rd_act = 1'b1;
      st_nxt.rd_beat = '0;
    end
    // Drive words on their own edges, release the bus when nothing is due
    if (edge_ok && fifo_out_valid) begin
      st_nxt.dout = fifo_out_data;
      st_nxt.oe = 1'b1;
      st_nxt.out_beat = st_r.out_beat + 1'b1;
    end else if ((ref_t_rise || ref_c_rise) && st_r.out_beat == '0 && !fifo_out_valid) begin
      st_nxt.oe = 1'b0;
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read data buffer
  // ----------------------------------------------------------------
  // Holds up to two bursts between fetch and output edges
  // Fetch runs one word per cycle, far ahead of the output edges
  qsb_fifo #(
    .WIDTH(`QSB_DATA_W),
    .DEPTH(`QSB_FIFO_DEPTH)
  ) u_rd_fifo (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .in_valid(st_r.rd_act),
    .in_ready(fifo_in_ready),
    .in_data(fetch_word),
    .out_valid(fifo_out_valid),
    .out_ready(edge_ok),
    .out_data(fifo_out_data)
  );

  // Outputs straight from the state register
  assign read_data_out = st_r.dout;
  assign read_data_oe = st_r.oe;
  assign echo_clock_true = st_r.echo_t;
  assign echo_clock_comp = st_r.echo_c;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // Read command latches the address and starts fetching
  read_addr_cap_a: assert property (rd_accept |=> st_r.rd_act && st_r.rd_addr == $past(address))
    else $error("read address not captured");
  // Write command latches the address with beat zero
  write_addr_cap_a: assert property (wr_accept |=> st_r.wr_act && st_r.wr_beat == 0 && st_r.wr_addr == $past(address))
    else $error("write address not captured");
  // Deselect leaves both address registers alone
  deselect_hold_a: assert property ((kt_rise && read_select_n && write_select_n)
    |=> $stable(st_r.rd_addr) && $stable(st_r.wr_addr))
    else $error("address taken on deselect cycle");
  // Read following a read on the next true edge is dropped
  read_ignore_a: assert property ((kt_rise && st_r.rd_block) |=> $stable(st_r.rd_addr) && !$rose(st_r.rd_act))
    else $error("back-to-back read accepted");
  // Address registers move only on a true input clock rise
  addr_true_only_a: assert property (!kt_rise |=> $stable(st_r.rd_addr) && $stable(st_r.wr_addr))
    else $error("address taken off the true edge");
  // A block lasts one true edge only, so the second edge accepts again
  block_clear_a: assert property ((kt_rise && !rd_accept && !wr_accept)
    |=> !st_r.rd_block && !st_r.wr_block)
    else $error("command block outlived one edge");
  // Write following a write on the next edge is dropped
  write_ignore_a: assert property ((kt_rise && st_r.wr_block) |=> $stable(st_r.wr_addr))
    else $error("back-to-back write accepted");
  // Fourth write beat ends the burst
  write_burst4_a: assert property ((st_r.wr_act && data_edge && st_r.wr_beat == 2'd3 && !wr_accept)
    |=> !st_r.wr_act)
    else $error("write burst not four beats");
  // All lanes disabled leaves memory untouched
  lanes_off_a: assert property ((st_r.wr_act && data_edge && byte_lane_enable_n == 4'hf) |=> $stable(st_r.mem))
    else $error("masked lanes written");

  // ----------------------------------------------------------------
  // Write path checks
  // ----------------------------------------------------------------
  // A beat with all lanes enabled stores its whole word, and storage moves only on a write beat
  write_word_a: assert property ((st_r.wr_act && data_edge && byte_lane_enable_n == 4'h0)
    |=> st_r.mem[$past(mem_index(st_r.wr_addr, st_r.wr_beat))] == $past(write_data_in))
    else $error("write word not stored");
  write_step_a: assert property ((st_r.wr_act && data_edge && !wr_accept)
    |=> st_r.wr_beat == $past(st_r.wr_beat) + 2'd1)
    else $error("write beat did not advance");
  write_idle_a: assert property (!(st_r.wr_act && data_edge) |=> $stable(st_r.mem))
    else $error("storage changed outside a write beat");
  // Lanes with their enable high keep their bits through a write beat
  for (genvar g = 0; g < `QSB_LANES; g++) begin : g_lane_chk
    lane_hold_a: assert property ((st_r.wr_act && data_edge && byte_lane_enable_n[g])
      |=> st_r.mem[$past(mem_index(st_r.wr_addr, st_r.wr_beat))][g*`QSB_LANE_W +: `QSB_LANE_W]
        == $past(st_r.mem[mem_index(st_r.wr_addr, st_r.wr_beat)][g*`QSB_LANE_W +: `QSB_LANE_W]))
      else $error("disabled lane written");
  end

  // ----------------------------------------------------------------
  // Read path checks
  // ----------------------------------------------------------------
  // Read fetch ends after its fourth word
  read_fetch4_a: assert property ((st_r.rd_act && fifo_in_ready && st_r.rd_beat == 2'd3 && !rd_accept)
    |=> !st_r.rd_act)
    else $error("read fetch not four words");
  // Each fetched word advances the beat by one
  read_step_a: assert property ((st_r.rd_act && fifo_in_ready && !rd_accept)
    |=> st_r.rd_beat == $past(st_r.rd_beat) + 2'd1)
    else $error("read beat did not advance");
  // First and third words go out on comp reference edges
  comp_slot_a: assert property ((edge_ok && fifo_out_valid && !st_r.out_beat[0]) |-> ref_c_rise)
    else $error("even beat on wrong edge");
  // Single-clock mode times output from input clock edges
  single_ref_a: assert property ((single_clk && edge_ok && fifo_out_valid) |-> (kt_rise || kc_rise))
    else $error("output not timed from input clocks");
  // Second and fourth words go out on true reference edges
  true_slot_a: assert property ((edge_ok && fifo_out_valid && st_r.out_beat[0]) |-> ref_t_rise)
    else $error("odd beat on wrong edge");
  // A burst opens the bus with its first word, taken on a comp reference edge
  oe_open_a: assert property ($rose(st_r.oe) |-> st_r.out_beat == 2'd1 && $past(ref_c_rise))
    else $error("bus opened on wrong edge");
  // Read data move only on a reference clock rise
  dout_edge_a: assert property ($changed(st_r.dout) |-> $past(ref_t_rise || ref_c_rise))
    else $error("read data changed off reference edge");
  // Bus released only when no word is waiting
  tristate_idle_a: assert property ($fell(st_r.oe) |-> $past(!fifo_out_valid) && st_r.out_beat == 0)
    else $error("bus released mid burst");

  // ----------------------------------------------------------------
  // Echo clock checks
  // ----------------------------------------------------------------
  // Echo clock copies the reference one cycle later
  echo_follow_a: assert property (single_clk |=> echo_clock_true == $past(input_clock_true))
    else $error("echo clock not following");
  // The comp echo follows its own input pin as well
  echo_comp_a: assert property (single_clk |=> echo_clock_comp == $past(input_clock_comp))
    else $error("comp echo not following");
  // With the output pair running, echoes copy the output pair
  echo_pair_a: assert property (!single_clk |=> echo_clock_true == $past(output_clock_true)
    && echo_clock_comp == $past(output_clock_comp))
    else $error("echo not following output clocks");

  // ----------------------------------------------------------------
  // Coverage of the main scenarios
  // ----------------------------------------------------------------

  read_burst_c: cover property (rd_accept ##[1:40] (st_r.oe && st_r.out_beat == 2'd0 && $past(st_r.out_beat) == 2'd3));
  write_burst_c: cover property (wr_accept ##[1:40] $fell(st_r.wr_act));
  single_mode_c: cover property (single_clk && edge_ok && fifo_out_valid);
  masked_write_c: cover property (st_r.wr_act && data_edge && byte_lane_enable_n == 4'ha);
  read_blocked_c: cover property (kt_rise && !read_select_n && st_r.rd_block);
endmodule : qsb_port

// *** testbench/qsb_ctrl_model.sv ***
// Memory controller clock model: input pair, output pair, single-clock option
`timescale 1ns/1ps
module qsb_ctrl_model (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic single_clk,
  output logic [2:0] ph_r,
  output logic input_clock_true,
  output logic input_clock_comp,
  output logic output_clock_true,
  output logic output_clock_comp
);
  // Phase counter, eight ref_clk cycles per input clock period
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ph_r <= 3'h0;
    end else begin
      ph_r <= ph_r + 3'h1;
    end
  end
  // Input pair in antiphase; output pair shifted half a period, or held high
  assign input_clock_true = ph_r[2];
  assign input_clock_comp = ~ph_r[2];
  assign output_clock_true = single_clk | ~ph_r[2];
  assign output_clock_comp = single_clk | ph_r[2];
endmodule : qsb_ctrl_model

// *** testbench/qsb_port_bench.sv ***
// Self-checking bench for the burst-four static RAM port
`timescale 1ns/1ps
module qsb_port_bench;
  import qsb_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic single_clk = 1'b0;
  logic [2:0] ph_r;
  logic input_clock_true, input_clock_comp, output_clock_true, output_clock_comp;
  qsb_addr_t address = 18'h0_0000;
  logic read_select_n = 1'b1;
  logic write_select_n = 1'b1;
  qsb_data_t write_data_in = 36'h0_0000_0000;
  qsb_lane_t byte_lane_enable_n = 4'hf;
  qsb_data_t read_data_out;
  logic read_data_oe, echo_clock_true, echo_clock_comp;
  qsb_data_t ref_mem [16][4];
  int err_count = 0;
  int check_count = 0;

  qsb_ctrl_model i_qsb_ctrl_model (.ref_clk, .reset_n, .single_clk, .ph_r, .input_clock_true,
    .input_clock_comp, .output_clock_true, .output_clock_comp);
  qsb_port i_qsb_port (.ref_clk, .reset_n, .input_clock_true, .input_clock_comp, .output_clock_true,
    .output_clock_comp, .address, .read_select_n, .write_select_n, .write_data_in, .byte_lane_enable_n,
    .read_data_out, .read_data_oe, .echo_clock_true, .echo_clock_comp);

  // 50 MHz clock
  always #10 ref_clk = ~ref_clk;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input qsb_data_t seen, input qsb_data_t exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic results;
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  // Stops at the edge where the model phase is p (old value, as the design sees it)
  task automatic wait_ph(input logic [2:0] p);
    do @(posedge ref_clk); while (ph_r !== p);
  endtask : wait_ph

  // Write burst; dup repeats the write select at the next true rise
  task automatic wr(input qsb_addr_t a, input qsb_data_t d0, input qsb_lane_t be, input bit dup);
    qsb_data_t w;
    wait_ph(3'h3);
    write_select_n <= 1'b0;
    address <= a;
    wait_ph(3'h4);
    write_select_n <= 1'b1;
    address <= a ^ 18'h0_0001;
    for (int i = 0; i < 4; i++) begin
      wait_ph(i[0] ? 3'h3 : 3'h7);
      w = d0 + i;
      write_select_n <= !(dup && i == 1);
      write_data_in <= w;
      byte_lane_enable_n <= be;
      for (int j = 0; j < 4; j++) begin
        if (!be[j]) ref_mem[a[3:0]][i][9*j +: 9] = w[9*j +: 9];
      end
    end
    wait_ph(3'h4);
    write_data_in <= ~write_data_in;
    byte_lane_enable_n <= 4'hf;
    #1;
    check(read_data_oe, 1'b0);
  endtask : wr

  // Read burst; collects four words and checks order, reference phase and bus release
  task automatic rd(input qsb_addr_t a, input bit dup);
    int n;
    qsb_data_t last;
    n = 0;
    fork
      for (int k = 0; k <= dup; k++) begin
        wait_ph(3'h3);
        read_select_n <= 1'b0;
        address <= k ? a ^ 18'h0_0001 : a;
        wait_ph(3'h4);
        read_select_n <= 1'b1;
        address <= ~a;
      end
      for (int c = 0; c < 80 && n < 4; c++) begin
        @(posedge ref_clk);
        #1;
        if (read_data_oe === 1'b1 && (n == 0 || read_data_out !== last)) begin
          last = read_data_out;
          check(read_data_out, ref_mem[a[3:0]][n]);
          check({echo_clock_true, echo_clock_comp}, {n[0], ~n[0]});
          n++;
        end
      end
    join
    for (int c = 0; c < 20 && read_data_oe !== 1'b0; c++) @(posedge ref_clk);
    repeat (16) begin
      @(posedge ref_clk);
      #1;
      if (read_data_oe !== 1'b0) n++;
    end
    check(n, 4);
  endtask : rd

  // Echo clocks follow the reference pins while the read bus is idle
  task automatic echo_idle;
    logic r;
    logic rt;
    repeat (16) begin
      @(posedge ref_clk);
      r = single_clk ? input_clock_comp : output_clock_comp;
      rt = single_clk ? input_clock_true : output_clock_true;
      #1;
      check(echo_clock_comp, r);
      check(echo_clock_true, rt);
      check(read_data_oe, 1'b0);
    end
  endtask : echo_idle

  // Main sequence
  initial begin
    foreach (ref_mem[x, y]) ref_mem[x][y] = '0;
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    echo_idle();
    wr(18'h0_0004, 36'h3_0000_0100, 4'h0, 1'b0);
    wr(18'h0_0005, 36'h1_2345_6780, 4'h0, 1'b0);
    rd(18'h0_0005, 1'b0);
    wr(18'h0_0005, 36'hA_BCDE_F010, 4'hA, 1'b1);
    rd(18'h0_0005, 1'b1);
    rd(18'h0_0004, 1'b0);
    single_clk <= 1'b1;
    echo_idle();
    rd(18'h0_0005, 1'b0);
    results();
  end

  // Watchdog: the whole run needs well under 600 cycles, so 5000 only ends a hang
  initial begin
    repeat (5000) @(posedge ref_clk);
    err_count++;
    results();
  end
endmodule : qsb_port_bench
